// ===== spct_core.sv
`timescale 1ns/10ps
module spct_core
   import spct_pkg::*;
(
   // Clock, reset and clock enable
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   input wire logic CE_I,
   // Configuration
   input wire spct_pkg::spct_gcr_s GLOBAL_CONTROL_WORD_I,
   input wire spct_pkg::spct_fmt_s FORMAT_CONFIG_WORD_I,
   input wire spct_pkg::spct_dly_s DELAY_CONFIG_REGISTER_I,
   input wire logic SELECT_HOLD_OPTION_I,
   // Transmit stream
   input wire logic [spct_pkg::WORD_W-1:0] TX_DATA_I,
   input wire logic TX_VALID_I,
   output logic TX_READY_O,
   // Receive buffer
   output logic [spct_pkg::WORD_W-1:0] RX_DATA_O,
   output logic RX_VALID_O,
   // Serial pins
   output logic SERIAL_CLOCK_LINE_O,
   output logic SERIAL_CLOCK_OE_N_O,
   output logic CONTROLLER_OUT_LINE_O,
   input wire logic CONTROLLER_IN_LINE_I,
   output logic SELECT_N_O
);
   import spct_pkg::*;

   spct_state_e state_r;
   spct_fmt_s fmt_r;
   spct_dly_s dly_r;
   logic [CNT_W-1:0] cnt_r;
   logic [4:0] bits_r;
   logic [4:0] len_r;
   logic [4:0] rx_cnt_r;
   logic sclk_r;
   logic cs_n_r;
   logic oe_n_r;
   logic samp_r;
   logic samp_q_r;
   logic in_s1_r;
   logic in_s2_r;
   logic [WORD_W-1:0] tx_r;
   logic [WORD_W-1:0] rx_sh_r;
   logic [WORD_W-1:0] rx_r;
   logic rx_vld_r;
   logic [WORD_W-1:0] q_data;
   logic q_valid;
   logic q_take;
   logic start;
   logic leading;
   logic [HALF_W-1:0] hi;
   logic [HALF_W-1:0] lo;
   logic [CNT_W-1:0] setup_ld;
   logic [4:0] new_len;

   spct_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_txq (
      .clk_i(CLOCK_I),
      .rst_i(RESET_I),
      .en_i(CE_I),
      .in_valid_i(TX_VALID_I),
      .in_data_i(TX_DATA_I),
      .in_ready_o(TX_READY_O),
      .out_valid_o(q_valid),
      .out_data_o(q_data),
      .out_ready_i(q_take)
   );

   // A transfer starts only in controller mode with phase zero selected.
   assign q_take = (state_r == ST_IDLE)
                   && GLOBAL_CONTROL_WORD_I.controller_mode
                   && !FORMAT_CONFIG_WORD_I.clock_phase;
   assign start = q_take && q_valid;
   assign hi = half_hi(fmt_r.clock_prescale);
   assign lo = half_lo(fmt_r.clock_prescale);
   assign leading = (sclk_r == fmt_r.clock_polarity);
   assign new_len = eff_len(FORMAT_CONFIG_WORD_I.word_len);
   assign setup_ld = CNT_W'(DELAY_CONFIG_REGISTER_I.select_to_clock_delay)
                     + SETUP_EXTRA - 10'h001
                     + CNT_W'(SELECT_HOLD_OPTION_I);

   assign SERIAL_CLOCK_LINE_O = sclk_r;
   assign SERIAL_CLOCK_OE_N_O = oe_n_r;
   assign CONTROLLER_OUT_LINE_O = tx_r[WORD_W-1];
   assign SELECT_N_O = cs_n_r;
   assign RX_DATA_O = rx_r;
   assign RX_VALID_O = rx_vld_r;

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         oe_n_r <= 1'b1;
      end else if (CE_I) begin
         oe_n_r <= !GLOBAL_CONTROL_WORD_I.controller_mode;
      end
   end

   // Sequencer: select setup, clock halves and select hold.
   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         state_r <= ST_IDLE;
         cnt_r <= CNT_RST;
         sclk_r <= 1'b0;
         cs_n_r <= 1'b1;
         bits_r <= '0;
         len_r <= '0;
         samp_r <= 1'b0;
         fmt_r <= '0;
         dly_r <= '0;
      end else if (CE_I) begin
         samp_r <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               sclk_r <= FORMAT_CONFIG_WORD_I.clock_polarity;
               if (start) begin
                  fmt_r <= FORMAT_CONFIG_WORD_I;
                  dly_r <= DELAY_CONFIG_REGISTER_I;
                  cs_n_r <= 1'b0;
                  bits_r <= new_len;
                  len_r <= new_len;
                  cnt_r <= setup_ld;
                  state_r <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_r == '0) begin
                  sclk_r <= !sclk_r;
                  cnt_r <= CNT_W'(hi) - 10'h001;
                  state_r <= ST_XFER;
               end else begin
                  cnt_r <= cnt_r - 10'h001;
               end
            end
            ST_XFER: begin
               if (cnt_r == '0) begin
                  sclk_r <= !sclk_r;
                  if (!leading) begin
                     // Trailing edge back to rest level is the sample edge.
                     samp_r <= 1'b1;
                     bits_r <= bits_r - 5'h01;
                     if (bits_r == 5'h01) begin
                        cnt_r <= CNT_W'(hi) + HOLD_EXTRA - 10'h001
                                 + CNT_W'(dly_r.clock_to_select_delay);
                        state_r <= ST_HOLD;
                     end else begin
                        cnt_r <= CNT_W'(lo) - 10'h001;
                     end
                  end else begin
                     cnt_r <= CNT_W'(hi) - 10'h001;
                  end
               end else begin
                  cnt_r <= cnt_r - 10'h001;
               end
            end
            ST_HOLD: begin
               if (cnt_r == '0) begin
                  cs_n_r <= 1'b1;
                  state_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 10'h001;
               end
            end
         endcase
      end
   end

   // The first bit is on the line from select assertion; later bits
   // change on leading edges so they stay valid across the sample edge.
   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         tx_r <= WORD_RST;
      end else if (CE_I) begin
         if (start) begin
            tx_r <= q_data << (WORD_W - int'(new_len));
         end else if (state_r == ST_XFER && cnt_r == '0 && leading
                      && bits_r != len_r) begin
            tx_r <= {tx_r[WORD_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         in_s1_r <= 1'b0;
         in_s2_r <= 1'b0;
      end else if (CE_I) begin
         in_s1_r <= CONTROLLER_IN_LINE_I;
         in_s2_r <= in_s1_r;
      end
   end

   // The synchroniser delays the pin by two cycles; the sample strobe is
   // delayed to match, so the bit taken is the one present at the edge.
   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         samp_q_r <= 1'b0;
         rx_sh_r <= WORD_RST;
         rx_cnt_r <= '0;
         rx_r <= WORD_RST;
         rx_vld_r <= 1'b0;
      end else if (CE_I) begin
         samp_q_r <= samp_r;
         rx_vld_r <= 1'b0;
         if (start) begin
            rx_sh_r <= WORD_RST;
            rx_cnt_r <= '0;
         end else if (samp_q_r) begin
            rx_sh_r <= {rx_sh_r[WORD_W-2:0], in_s2_r};
            rx_cnt_r <= rx_cnt_r + 5'h01;
            if (rx_cnt_r + 5'h01 == len_r) begin
               rx_r <= {rx_sh_r[WORD_W-2:0], in_s2_r};
               rx_vld_r <= 1'b1;
            end
         end
      end
   end

   // Helper logic read only by the checks below.
   logic sclk_q_r;
   logic run_r;
   logic [CNT_W-1:0] gap_r;
   logic [CNT_W-1:0] cs_age_r;
   logic [4:0] samp_cnt_r;
   logic hold_r;
   logic tog;

   assign tog = (sclk_r != sclk_q_r) && !cs_n_r;

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         sclk_q_r <= 1'b0;
         run_r <= 1'b0;
         gap_r <= CNT_RST;
         cs_age_r <= CNT_RST;
         samp_cnt_r <= '0;
         hold_r <= 1'b0;
      end else if (CE_I) begin
         hold_r <= start ? SELECT_HOLD_OPTION_I : hold_r;
         sclk_q_r <= sclk_r;
         run_r <= cs_n_r ? 1'b0 : (run_r || tog);
         gap_r <= tog ? 10'h001 : gap_r + 10'h001;
         cs_age_r <= cs_n_r ? CNT_RST : cs_age_r + 10'h001;
         samp_cnt_r <= cs_n_r ? 5'h00 : samp_cnt_r + 5'(samp_r);
      end
   end

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RESET_I);

   sequence seq_select_fall;
      $fell(cs_n_r);
   endsequence

   sequence seq_select_rise;
      $rose(cs_n_r);
   endsequence

   chk_half_len: assert property (
      (tog && run_r) |-> gap_r == CNT_W'((sclk_q_r != fmt_r.clock_polarity)
                                          ? hi : lo))
      else $error("serial clock half period length wrong");

   chk_prescale_period: assert property (
      (state_r == ST_XFER) |-> (CNT_W'(hi) + CNT_W'(lo)) ==
         ((fmt_r.clock_prescale == 8'h00) ? 10'h002
          : CNT_W'(fmt_r.clock_prescale) + 10'h001))
      else $error("serial clock period does not follow prescale");

   chk_ctrl_select: assert property (
      seq_select_fall |-> $past(GLOBAL_CONTROL_WORD_I.controller_mode)
                          && !oe_n_r)
      else $error("transfer started outside controller mode");

   chk_phase_zero: assert property (
      seq_select_fall |-> !$past(FORMAT_CONFIG_WORD_I.clock_phase))
      else $error("transfer started with clock phase one");

   chk_capture_edge: assert property (
      samp_r |-> (sclk_r == fmt_r.clock_polarity) && (sclk_q_r != sclk_r))
      else $error("sample taken on the wrong serial clock edge");

   chk_setup_wait: assert property (
      (tog && !run_r) |-> cs_age_r == CNT_W'(dly_r.select_to_clock_delay)
                          + SETUP_EXTRA + CNT_W'(hold_r))
      else $error("select to first clock edge wait wrong");

   chk_hold_time: assert property (
      seq_select_rise |-> gap_r == CNT_W'(hi) + HOLD_EXTRA
                           + CNT_W'(dly_r.clock_to_select_delay))
      else $error("select hold after last edge wrong");

   chk_word_bits: assert property (
      seq_select_rise |-> samp_cnt_r == len_r ##[1:3] 1'b1)
      else $error("bit count per word wrong");

   chk_rx_word: assert property (
      (samp_q_r && rx_cnt_r + 5'h01 == len_r && CE_I) |=> rx_vld_r)
      else $error("receive word not delivered");

   chk_idle_level: assert property (
      (cs_n_r && state_r == ST_IDLE && $past(state_r) == ST_IDLE
       && $past(CE_I && !RESET_I)
       && $stable(FORMAT_CONFIG_WORD_I.clock_polarity))
      |-> sclk_r == FORMAT_CONFIG_WORD_I.clock_polarity)
      else $error("idle serial clock not at rest level");

endmodule

// ===== spct_dummy_note_unused.sv
`timescale 1ns/10ps

// ===== spct_fifo.sv
`timescale 1ns/10ps
module spct_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic [AW:0] count_nxt;
   logic ready_r;
   logic push;
   logic pop;

   assign push = en_i && in_valid_i && ready_r;
   assign pop = en_i && out_valid_o && out_ready_i;
   assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
   assign in_ready_o = ready_r;
   assign out_valid_o = (count_r != '0);
   assign out_data_o = mem_r[rd_ptr_r];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // Ready is registered so the fill side never sees a path through pop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ready_r <= 1'b0;
      end else if (en_i) begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
         ready_r <= (count_nxt != (AW+1)'(DEPTH));
      end
   end

endmodule

// ===== spct_pkg.sv
package spct_pkg;

   // Data word, transmit queue and counter dimensions.
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam int CNT_W = 10;
   localparam int HALF_W = 9;

   // Word length limits, in bits.
   localparam logic [4:0] LEN_MIN = 5'h02;
   localparam logic [4:0] LEN_MAX = 5'h10;

   // Extra peripheral clock cycles in the select-to-clock and
   // clock-to-select waits.
   localparam logic [CNT_W-1:0] SETUP_EXTRA = 10'h002;
   localparam logic [CNT_W-1:0] HOLD_EXTRA = 10'h001;

   // Field positions inside the configuration words.
   localparam int GCR_CTRL_BIT = 0;
   localparam int FMT_LEN_LSB = 0;
   localparam int FMT_PRESCALE_LSB = 8;
   localparam int FMT_PHASE_BIT = 16;
   localparam int FMT_POLARITY_BIT = 17;
   localparam int DLY_T2C_LSB = 16;
   localparam int DLY_C2T_LSB = 24;

   // Reset values.
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 10'h000;

   typedef struct packed {
      logic [30:0] rsvd;
      logic controller_mode;
   } spct_gcr_s;

   typedef struct packed {
      logic [13:0] rsvd_hi;
      logic clock_polarity;
      logic clock_phase;
      logic [7:0] clock_prescale;
      logic [2:0] rsvd_lo;
      logic [4:0] word_len;
   } spct_fmt_s;

   typedef struct packed {
      logic [7:0] select_to_clock_delay;
      logic [7:0] clock_to_select_delay;
      logic [15:0] rsvd;
   } spct_dly_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_XFER = 2'b10,
      ST_HOLD = 2'b11
   } spct_state_e;

   // Serial clock period in peripheral clock cycles.
   function automatic logic [HALF_W-1:0] period(input logic [7:0] p);
      period = (p == 8'h00) ? 9'h002 : {1'b0, p} + 9'h001;
   endfunction

   // Active phase takes the larger half when the period is odd.
   function automatic logic [HALF_W-1:0] half_hi(input logic [7:0] p);
      half_hi = (period(p) + 9'h001) >> 1;
   endfunction

   function automatic logic [HALF_W-1:0] half_lo(input logic [7:0] p);
      half_lo = period(p) - half_hi(p);
   endfunction

   function automatic logic [4:0] eff_len(input logic [4:0] l);
      if (l < LEN_MIN) begin
         eff_len = LEN_MIN;
      end else if (l > LEN_MAX) begin
         eff_len = LEN_MAX;
      end else begin
         eff_len = l;
      end
   endfunction

endpackage

// ===== spct_target.sv
`timescale 1ns/10ps
// Behavioural serial target for the phase zero controller timing checks.
module spct_target (
   // Serial pins
   input wire logic clk_line_i,
   input wire logic sel_n_i,
   input wire logic out_line_i,
   output logic in_line_o,
   // Frame set-up from the bench
   input wire logic pol_i,
   input wire logic [15:0] reply_i,
   input wire logic [4:0] len_i,
   // What the target collected
   output logic [15:0] got_o,
   output logic [4:0] count_o
);
   int idx;

   initial begin
      in_line_o = 1'b0;
      got_o = 16'h0000;
      count_o = 5'h00;
      idx = 0;
   end

   // The first reply bit is on the line as soon as the frame opens.
   always @(negedge sel_n_i) begin
      got_o = 16'h0000;
      count_o = 5'h00;
      idx = int'(len_i) - 1;
      in_line_o = reply_i[idx];
   end

   // Data changes on the leading edge only, so it is stable across the
   // trailing edge where the controller samples it.
   always @(clk_line_i) begin
      if (sel_n_i === 1'b0) begin
         if (clk_line_i === pol_i) begin
            got_o = {got_o[14:0], out_line_i};
            count_o = count_o + 5'h01;
            idx = idx - 1;
         end else if (count_o != 5'h00 && idx >= 0) begin
            in_line_o = reply_i[idx];
         end
      end
   end

   // A released line must not keep showing its last bit.
   always @(posedge sel_n_i) begin
      in_line_o = ~in_line_o;
   end
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
   import spct_pkg::*;
   logic CLOCK_I, RESET_I, ce, hold, tx_valid, tx_ready, rx_valid;
   logic sclk, oe_n, mosi, miso, sel_n, prev_sel, prev_clk;
   spct_gcr_s gcr;
   spct_fmt_s fmt;
   spct_dly_s dly;
   logic [15:0] tx_data, rx_data, reply, got;
   logic [4:0] eff, count;
   logic [15:0] exp_rx[$], exp_tx[$];
   logic [4:0] exp_len[$];
   int bad_count, num_checks, cyc, t_sel, t_lead, t_trail, nlead, per, hi;
   logic [4:0] lens[8] = '{5'h02, 5'h10, 5'h01, 5'h14, 5'h07, 5'h0C,
                           5'h00, 5'h1F};
   logic [7:0] ps[8] = '{8'h00, 8'h01, 8'h02, 8'hFF, 8'h04, 8'h03, 8'h00,
                         8'h05};
   logic [7:0] c2ts[8] = '{8'h00, 8'h03, 8'hFF, 8'h01, 8'h00, 8'h08, 8'h02,
                           8'h00};
   logic [7:0] t2cs[8] = '{8'h00, 8'hFF, 8'h01, 8'h04, 8'h00, 8'h02, 8'h07,
                           8'h03};

   spct_core dut_u (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .CE_I(ce),
      .GLOBAL_CONTROL_WORD_I(gcr), .FORMAT_CONFIG_WORD_I(fmt),
      .DELAY_CONFIG_REGISTER_I(dly), .SELECT_HOLD_OPTION_I(hold),
      .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready),
      .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
      .SERIAL_CLOCK_LINE_O(sclk), .SERIAL_CLOCK_OE_N_O(oe_n),
      .CONTROLLER_OUT_LINE_O(mosi), .CONTROLLER_IN_LINE_I(miso),
      .SELECT_N_O(sel_n));

   spct_target peer_u (.clk_line_i(sclk), .sel_n_i(sel_n),
      .out_line_i(mosi), .in_line_o(miso), .pol_i(fmt.clock_polarity),
      .reply_i(reply), .len_i(eff), .got_o(got), .count_o(count));

   initial begin
      CLOCK_I = 1'b0;
      forever #2 CLOCK_I = ~CLOCK_I;
   end

   function automatic logic [15:0] msk(input logic [4:0] e);
      msk = 16'hFFFF >> (5'h10 - e);
   endfunction

   task check(input string what, input logic [31:0] seen,
              input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task results;
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task setup(input logic [4:0] len, input logic [7:0] p, input logic pol,
              input logic [7:0] c2t, input logic [7:0] t2c, input logic h);
      @(posedge CLOCK_I);
      #1;
      fmt.word_len = len;
      fmt.clock_prescale = p;
      fmt.clock_polarity = pol;
      dly.select_to_clock_delay = c2t;
      dly.clock_to_select_delay = t2c;
      hold = h;
      eff = (len < 5'h02) ? 5'h02 : (len > 5'h10) ? 5'h10 : len;
      per = (p == 8'h00) ? 2 : int'(p) + 1;
      hi = (per + 1) / 2;
      reply = 16'($urandom);
   endtask

   task note(input logic [15:0] d);
      exp_tx.push_back(d & msk(eff));
      exp_rx.push_back(reply & msk(eff));
      exp_len.push_back(eff);
   endtask

   task push(input logic [15:0] d);
      int n;
      @(posedge CLOCK_I);
      #1;
      tx_valid = 1'b1;
      tx_data = d;
      n = 0;
      do begin
         @(posedge CLOCK_I);
         n++;
      end while (tx_ready !== 1'b1 && n < 100);
      note(d);
      #1 tx_valid = 1'b0;
   endtask

   task drain;
      int n;
      n = 0;
      while ((exp_rx.size() != 0 || exp_tx.size() != 0) && n < 20000) begin
         @(posedge CLOCK_I);
         n++;
      end
      check("frames finished", n < 20000, 1);
   endtask

   // Monitor samples at the falling edge, where the registered outputs
   // have settled, so every difference of cycle counts below is exact.
   always @(negedge CLOCK_I) begin
      cyc++;
      if (RESET_I === 1'b0) begin
         if (prev_sel === 1'b1 && sel_n === 1'b0) begin
            t_sel = cyc;
            nlead = 0;
            check("rest level", prev_clk, fmt.clock_polarity);
            check("clock driven", oe_n, 0);
         end
         if (sel_n === 1'b0 && prev_clk === fmt.clock_polarity &&
             sclk === ~fmt.clock_polarity) begin
            if (nlead == 0) begin
               check("setup", cyc - t_sel,
                     dly.select_to_clock_delay + 2 + hold);
            end else begin
               check("period", cyc - t_lead, per);
            end
            nlead++;
            t_lead = cyc;
         end
         if (sel_n === 1'b0 && prev_clk === ~fmt.clock_polarity &&
             sclk === fmt.clock_polarity) begin
            check("active phase", cyc - t_lead, hi);
            t_trail = cyc;
         end
         if (prev_sel === 1'b0 && sel_n === 1'b1) begin
            check("hold", cyc - t_trail,
                  hi + dly.clock_to_select_delay + 1);
            check("sent word", got, exp_tx.pop_front());
            check("bit count", count, exp_len.pop_front());
         end
         if (rx_valid === 1'b1) begin
            if (exp_rx.size() == 0) begin
               check("unexpected word", 1, 0);
            end else begin
               check("received word", rx_data, exp_rx.pop_front());
            end
         end
      end
      prev_sel = sel_n;
      prev_clk = sclk;
   end

   initial begin
      #300000;
      bad_count++;
      results;
   end

   initial begin
      int n;
      RESET_I = 1'b1;
      ce = 1'b1;
      gcr = '0;
      fmt = '0;
      dly = '0;
      hold = 1'b0;
      tx_valid = 1'b0;
      tx_data = 16'h0000;
      reply = 16'h0000;
      eff = 5'h02;
      cyc = 0;
      void'($urandom(32'h8939C446));
      repeat (8) @(posedge CLOCK_I);
      #1 RESET_I = 1'b0;
      check("select idle", sel_n, 1);
      // With controller mode off the queue fills and nothing goes out.
      setup(5'h08, 8'h01, 1'b0, 8'h00, 8'h00, 1'b0);
      tx_valid = 1'b1;
      tx_data = 16'($urandom);
      n = 0;
      repeat (10) begin
         @(posedge CLOCK_I);
         if (tx_ready === 1'b1) begin
            note(tx_data);
            n++;
            #1 tx_data = 16'($urandom);
         end
      end
      #1 tx_valid = 1'b0;
      check("queue depth", n, FIFO_DEPTH);
      check("no frame", sel_n, 1);
      check("clock released", oe_n, 1);
      gcr.controller_mode = 1'b1;
      drain;
      // Format table, two frames back to back each.
      for (int i = 0; i < 8; i++) begin
         setup(lens[i], ps[i], i[0], c2ts[i], t2cs[i], i[1]);
         push(16'($urandom));
         push(16'($urandom));
         drain;
      end
      // Phase one keeps the word queued until phase zero returns.
      setup(5'h05, 8'h02, 1'b1, 8'h01, 8'h01, 1'b1);
      fmt.clock_phase = 1'b1;
      push(16'($urandom));
      repeat (40) @(posedge CLOCK_I);
      check("phase one idle", sel_n, 1);
      // A low clock enable keeps the queued word waiting after phase zero.
      #1 fmt.clock_phase = 1'b0;
      ce = 1'b0;
      repeat (20) @(posedge CLOCK_I);
      check("frozen idle", sel_n, 1);
      #1 ce = 1'b1;
      drain;
      results;
   end
endmodule
